//--- logic/ucfg_params.svh
`ifndef UCFG_PARAMS_SVH
`define UCFG_PARAMS_SVH
`define UCFG_CFG_OFS 16'h4000
`define UCFG_LKB_OFS 16'h4002
`define UCFG_CFG_RST 16'h0004
`define UCFG_LKB_RST 10'h000
`define UCFG_B_STRUCT 0
`define UCFG_B_UNI 1
`define UCFG_B_EXTCLK 2
`define UCFG_B_OAM 3
`define UCFG_B_BUS8 4
`define UCFG_B_LVL1 5
`define UCFG_B_UNK 6
`define UCFG_B_CAVF 7
`define UCFG_B_TXF 8
`define UCFG_B_PHY 9
`define UCFG_ADR_HI 14
`define UCFG_ADR_LO 10
`define UCFG_B_DONE 15
`define UCFG_ADR_MAX 5'h1e
`define UCFG_M_HI 3
`define UCFG_M_LO 0
`define UCFG_N_HI 8
`define UCFG_N_LO 4
`define UCFG_B_PAUSE 9
`define UCFG_UNI_VPI_MASK 12'h0ff
`endif

//--- logic/ucfg_pkg.sv
package ucfg_pkg;
	typedef enum logic [1:0] {
		UCFG_IDLE = 2'h0,
		UCFG_POLL = 2'h1,
		UCFG_CELL = 2'h3,
		UCFG_PAUSE = 2'h2
	} ucfg_rx_e;
	typedef struct packed {
		logic [15:0] cfg;
		logic [9:0] lkb;
		logic [15:0] rd;
		logic div;
		logic clk_oe;
		logic rxc1, rxc2, rxc3;
		logic txc1, txc2, txc3;
		logic [4:0] rxa1, rxa2, txa1, txa2;
		ucfg_rx_e st;
		logic polled;
		logic cav, cav_oe, rxe;
		logic [15:0] txd;
		logic txsoc, txoe;
		logic keep, drop, lreq;
	} ucfg_s;
endpackage

//--- logic/ucfg_top.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "ucfg_params.svh"
// Function
// - Config bit 0 set selects structured handling, clear selects unstructured.
// - Unstructured compares header against identifiers first; structured goes to table.
// - Bit 1 set is user-network format; network format compares flow control.
// - Bit 2 set takes cell clocks from pins; clear drives them at half clock.
// - Bit 3 set keeps maintenance cells; clear discards them.
// - Bit 4 set gives eight-bit bus, clear sixteen-bit.
// - Bit 5 set is bus level 1, clear is level 2.
// - Bit 6 set keeps unknown-route cells, clear discards them.
// - Bit 7 set always drives cell-available; clear floats it when unpolled.
// - Bit 8 set always drives outgoing start and data; clear floats them unless set up, active and ATM role, level 1 or selected.
// - Bit 9 set is physical-layer role, clear is ATM-layer role.
// - Five-bit device address matches address buses; only 00h to 1Eh valid.
// - Four-bit field counts path identifier bits for look-ups, 0 to 12.
// - Five-bit field counts channel identifier bits for look-ups, 4 to 16.
// - Pause enable drives receive enable high after every received cell.
// - Config register resets to 0004, external clock, all else clear.
module ucfg_top import ucfg_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rd_data,
	input wire logic i_rx_cell_clock,
	output logic o_rx_cell_clock,
	output logic o_rx_cell_clock_oe,
	input wire logic i_tx_cell_clock,
	output logic o_tx_cell_clock,
	output logic o_tx_cell_clock_oe,
	input wire logic [4:0] i_rx_port_addr_bus,
	input wire logic [4:0] i_tx_port_addr_bus,
	output logic o_cell_avail,
	output logic o_cell_avail_oe,
	output logic o_rx_enable_or_avail,
	input wire logic i_rx_room,
	input wire logic i_rx_cell_end,
	input wire logic [15:0] i_tx_word,
	input wire logic i_tx_soc,
	input wire logic i_tx_active,
	output logic [15:0] o_tx_cell_bus,
	output logic o_tx_start_of_cell,
	output logic o_tx_bus_oe,
	input wire logic i_hdr_valid,
	input wire logic i_hdr_oam,
	input wire logic [11:0] i_hdr_vpi,
	input wire logic [15:0] i_hdr_vci,
	input wire logic [11:0] i_udt_vpi,
	input wire logic [15:0] i_udt_vci,
	input wire logic i_lut_done,
	input wire logic i_lut_known,
	output logic o_cell_keep,
	output logic o_cell_drop,
	output logic o_lut_req,
	output logic [15:0] o_cell_port_config,
	output logic [9:0] o_header_lookup_bits
);
	logic rst1_r, rst_n;
	ucfg_s q, d;
	logic done, edge_rx, edge_tx, addr_ok, rx_hit, tx_hit, lvl1, udt_hit;
	logic [11:0] vmask;

	// Reset is released through two flops
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst1_r <= 1'b1;
			rst_n <= rst1_r;
		end
	end

	always_comb begin
		d = q;
		done = q.cfg[`UCFG_B_DONE];
		lvl1 = q.cfg[`UCFG_B_LVL1];
		// Address 1Fh is the idle address on the bus, never ours
		addr_ok = q.cfg[`UCFG_ADR_HI:`UCFG_ADR_LO] <= `UCFG_ADR_MAX;
		rx_hit = addr_ok && q.rxa2 == q.cfg[`UCFG_ADR_HI:`UCFG_ADR_LO];
		tx_hit = addr_ok && q.txa2 == q.cfg[`UCFG_ADR_HI:`UCFG_ADR_LO];
		// Register port
		if (i_wr && i_addr == `UCFG_CFG_OFS) begin
			d.cfg = i_wr_data;
		end
		if (i_wr && i_addr == `UCFG_LKB_OFS) begin
			d.lkb = i_wr_data[9:0];
		end
		d.rd = 16'h0000;
		if (i_rd && i_addr == `UCFG_CFG_OFS) begin
			d.rd = q.cfg;
		end else if (i_rd && i_addr == `UCFG_LKB_OFS) begin
			d.rd = {6'h00, q.lkb};
		end
		// Internal clock toggles every cycle, half the core rate
		d.div = !q.div;
		d.clk_oe = !q.cfg[`UCFG_B_EXTCLK];
		d.rxc1 = i_rx_cell_clock;
		d.rxc2 = q.rxc1;
		d.rxc3 = q.rxc2;
		d.txc1 = i_tx_cell_clock;
		d.txc2 = q.txc1;
		d.txc3 = q.txc2;
		d.rxa1 = i_rx_port_addr_bus;
		d.rxa2 = q.rxa1;
		d.txa1 = i_tx_port_addr_bus;
		d.txa2 = q.txa1;
		if (q.cfg[`UCFG_B_EXTCLK]) begin
			edge_rx = q.rxc2 && !q.rxc3;
			edge_tx = q.txc2 && !q.txc3;
		end else begin
			edge_rx = !q.div;
			edge_tx = !q.div;
		end
		// Receive side: poll, cell, optional pause
		case (q.st)
			UCFG_IDLE: begin
				if (done && edge_rx) begin
					d.st = UCFG_POLL;
				end
			end
			UCFG_POLL: begin
				if (edge_rx && i_rx_room && (lvl1 || rx_hit)) begin
					d.st = UCFG_CELL;
				end
			end
			UCFG_CELL: begin
				if (i_rx_cell_end) begin
					d.st = q.lkb[`UCFG_B_PAUSE] ? UCFG_PAUSE : UCFG_POLL;
				end
			end
			UCFG_PAUSE: begin
				if (edge_rx) begin
					d.st = UCFG_POLL;
				end
			end
			default: d.st = UCFG_IDLE;
		endcase
		if (!done) begin
			d.st = UCFG_IDLE;
		end
		// Enable stays high while idle, paused or full
		d.rxe = d.st == UCFG_IDLE || d.st == UCFG_PAUSE || !i_rx_room;
		if (edge_rx) begin
			d.polled = lvl1 || rx_hit;
			d.cav = done && i_rx_room;
		end
		// Level 1 has no polling, so the line is always ours
		d.cav_oe = q.cfg[`UCFG_B_CAVF] || q.polled;
		if (edge_tx) begin
			d.txd = q.cfg[`UCFG_B_BUS8] ? {8'h00, i_tx_word[7:0]} : i_tx_word;
			d.txsoc = i_tx_active && i_tx_soc;
		end
		// Clearing setup-done silences start-of-cell at once, not at the next link edge
		if (!done) begin
			d.txsoc = 1'b0;
		end
		// ATM role owns its outgoing bus; PHY role only at level 1 or when selected
		d.txoe = q.cfg[`UCFG_B_TXF] || (done && i_tx_active &&
			(lvl1 || !q.cfg[`UCFG_B_PHY] || tx_hit));
		// Header disposition
		vmask = q.cfg[`UCFG_B_UNI] ? `UCFG_UNI_VPI_MASK : 12'hfff;
		udt_hit = i_hdr_vci == i_udt_vci && ((i_hdr_vpi ^ i_udt_vpi) & vmask) == 12'h000;
		d.keep = 1'b0;
		d.drop = 1'b0;
		d.lreq = 1'b0;
		if (done && i_hdr_valid) begin
			if (i_hdr_oam) begin
				d.keep = q.cfg[`UCFG_B_OAM];
				d.drop = !q.cfg[`UCFG_B_OAM];
			end else if (q.cfg[`UCFG_B_STRUCT]) begin
				d.lreq = 1'b1;
			end else if (udt_hit) begin
				d.keep = 1'b1;
			end else begin
				d.lreq = 1'b1;
			end
		end else if (done && i_lut_done) begin
			d.keep = i_lut_known || q.cfg[`UCFG_B_UNK];
			d.drop = !i_lut_known && !q.cfg[`UCFG_B_UNK];
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.cfg <= `UCFG_CFG_RST;
			q.lkb <= `UCFG_LKB_RST;
			q.st <= UCFG_IDLE;
			q.rxe <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign o_rd_data = q.rd;
	assign o_rx_cell_clock = q.div;
	assign o_tx_cell_clock = q.div;
	assign o_rx_cell_clock_oe = q.clk_oe;
	assign o_tx_cell_clock_oe = q.clk_oe;
	assign o_cell_avail = q.cav;
	assign o_cell_avail_oe = q.cav_oe;
	assign o_rx_enable_or_avail = q.rxe;
	assign o_tx_cell_bus = q.txd;
	assign o_tx_start_of_cell = q.txsoc;
	assign o_tx_bus_oe = q.txoe;
	assign o_cell_keep = q.keep;
	assign o_cell_drop = q.drop;
	assign o_lut_req = q.lreq;
	assign o_cell_port_config = q.cfg;
	assign o_header_lookup_bits = q.lkb;

	cfg_reset_a: assert property (@(posedge i_clk)
		!$past(rst_n) && rst_n |-> q.cfg == `UCFG_CFG_RST)
		else $error("config reset value wrong");
	rd_data_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == `UCFG_CFG_OFS |=> o_rd_data == $past(q.cfg))
		else $error("config readback wrong");
	int_clock_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!q.cfg[`UCFG_B_EXTCLK] ##1 !q.cfg[`UCFG_B_EXTCLK]
		|-> o_rx_cell_clock != $past(o_rx_cell_clock) && o_rx_cell_clock_oe)
		else $error("internal cell clock not at half rate");
	ext_clock_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_EXTCLK] |=> !o_rx_cell_clock_oe && !o_tx_cell_clock_oe)
		else $error("cell clock driven in external mode");
	idle_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!done ##1 !done |-> o_rx_enable_or_avail && !o_tx_start_of_cell && !o_lut_req)
		else $error("cell logic active before setup");
	oam_drop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && i_hdr_oam && !q.cfg[`UCFG_B_OAM] |=> o_cell_drop && !o_cell_keep)
		else $error("maintenance cell not dropped");
	unknown_route_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && !i_hdr_valid && i_lut_done && !i_lut_known
		|=> o_cell_keep == $past(q.cfg[`UCFG_B_UNK]) && o_cell_drop != o_cell_keep)
		else $error("unknown route disposition wrong");
	struct_lut_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && !i_hdr_oam && q.cfg[`UCFG_B_STRUCT] |=> o_lut_req && !o_cell_keep)
		else $error("structured cell skipped table");
	pause_high_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.st == UCFG_CELL && i_rx_cell_end && q.lkb[`UCFG_B_PAUSE] && done
		|=> q.st == UCFG_PAUSE && o_rx_enable_or_avail)
		else $error("no pause after cell");
	cav_force_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_CAVF] |=> o_cell_avail_oe)
		else $error("cell available floated while forced");
	tx_force_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_TXF] |=> o_tx_bus_oe)
		else $error("outgoing bus floated while forced");
	// Header disposition by mode
	udt_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && !i_hdr_oam && !q.cfg[`UCFG_B_STRUCT] && udt_hit
		|=> o_cell_keep && !o_lut_req)
		else $error("matching unstructured cell not kept");
	udt_miss_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && !i_hdr_oam && !q.cfg[`UCFG_B_STRUCT] && !udt_hit
		|=> o_lut_req && !o_cell_keep)
		else $error("unmatched unstructured cell not looked up");
	nni_gfc_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && !i_hdr_oam && !q.cfg[`UCFG_B_STRUCT] && !q.cfg[`UCFG_B_UNI]
		&& i_hdr_vpi[11:8] != i_udt_vpi[11:8] |=> o_lut_req && !o_cell_keep)
		else $error("flow control ignored in network format");
	oam_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && i_hdr_oam && q.cfg[`UCFG_B_OAM]
		|=> o_cell_keep && !o_cell_drop)
		else $error("maintenance cell not kept");
	rx_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!done |=> q.st == UCFG_IDLE)
		else $error("receive side left idle before setup");
	cav_value_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		edge_rx |=> o_cell_avail == ($past(done) && $past(i_rx_room)))
		else $error("cell available level wrong");
	level1_poll_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		lvl1 && edge_rx |=> q.polled)
		else $error("level 1 port not treated as polled");
	bad_addr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!lvl1 && q.cfg[`UCFG_ADR_HI:`UCFG_ADR_LO] > `UCFG_ADR_MAX && edge_rx
		|=> !q.polled)
		else $error("invalid device address answered a poll");
	phy_unsel_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_PHY] && !lvl1 && !q.cfg[`UCFG_B_TXF] && !tx_hit |=> !o_tx_bus_oe)
		else $error("unselected physical-layer port drove the bus");
	atm_drive_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		done && i_tx_active && !q.cfg[`UCFG_B_PHY] |=> o_tx_bus_oe)
		else $error("ATM-layer port released its outgoing bus");
	bus8_upper_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_BUS8] && edge_tx |=> o_tx_cell_bus[15:8] == 8'h00)
		else $error("upper byte driven in eight-bit mode");
	bus16_word_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!q.cfg[`UCFG_B_BUS8] && edge_tx |=> o_tx_cell_bus == $past(i_tx_word))
		else $error("sixteen-bit word not passed whole");
	pause_stay_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		q.st == UCFG_PAUSE |-> o_rx_enable_or_avail)
		else $error("enable low during pause");
	lkb_read_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == `UCFG_LKB_OFS |=> o_rd_data == {6'h00, $past(q.lkb)})
		else $error("look-up bit count readback wrong");
	cv_cell_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		q.st == UCFG_POLL ##1 q.st == UCFG_CELL);
	cv_pause_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		q.st == UCFG_PAUSE ##[1:20] q.st == UCFG_POLL);
	cv_udt_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		done && i_hdr_valid && !q.cfg[`UCFG_B_STRUCT] && udt_hit);
	cv_phy_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_PHY] && !lvl1 && tx_hit && i_tx_active);
	cv_bus8_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		q.cfg[`UCFG_B_BUS8] && edge_tx && done);
endmodule // ucfg_top

//--- tb/ucfg_far_end.sv
`timescale 1ns/1ps
module ucfg_far_end (
	input wire logic i_run,
	input wire logic [4:0] i_addr,
	output logic o_clk,
	output logic [4:0] o_rx_addr,
	output logic [4:0] o_tx_addr
);
	// Odd start offset keeps the link clock unrelated in phase to the core clock
	initial begin
		o_clk = 1'b0;
		#37;
		forever begin
			#100;
			o_clk = i_run ? ~o_clk : 1'b0;
		end
	end
	assign o_rx_addr = i_addr;
	assign o_tx_addr = i_addr;
endmodule // ucfg_far_end

//--- tb/utopia_port_config_bench.sv
`timescale 1ns/1ps
module utopia_port_config_bench;
	logic clk, arst_n, wr, rd, run, room, cend, tsoc, tact, hv, oam, ld, lk, lclk;
	logic [15:0] addr, wd, rdd, tw, tbus, vci, uc;
	logic [11:0] vpi, uv;
	logic [4:0] pa, rxa, txa;
	logic rco, rcoe, tco, tcoe, cav, cavoe, rxe, tsoco, toe, keep, drop, lreq;
	logic [15:0] cfgo;
	logic [9:0] lkbo;
	logic [15:0] tc [10] = '{16'h0004, 16'h8004, 16'h800c, 16'h8004, 16'h8005, 16'h8004,
		16'h8044, 16'h8004, 16'h8006, 16'h8004};
	logic [2:0] tm [10] = '{3'h0, 3'h4, 3'h4, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3};
	logic [2:0] te [10] = '{3'h0, 3'h2, 3'h4, 3'h4, 3'h1, 3'h2, 3'h4, 3'h1, 3'h4, 3'h4};
	int num_errors = 0;
	int checked = 0;

	ucfg_top DUT (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wr_data(wd), .i_wr(wr),
		.i_rd(rd), .o_rd_data(rdd), .i_rx_cell_clock(lclk), .o_rx_cell_clock(rco),
		.o_rx_cell_clock_oe(rcoe), .i_tx_cell_clock(lclk), .o_tx_cell_clock(tco),
		.o_tx_cell_clock_oe(tcoe), .i_rx_port_addr_bus(rxa), .i_tx_port_addr_bus(txa),
		.o_cell_avail(cav), .o_cell_avail_oe(cavoe), .o_rx_enable_or_avail(rxe),
		.i_rx_room(room), .i_rx_cell_end(cend), .i_tx_word(tw), .i_tx_soc(tsoc),
		.i_tx_active(tact), .o_tx_cell_bus(tbus), .o_tx_start_of_cell(tsoco),
		.o_tx_bus_oe(toe), .i_hdr_valid(hv), .i_hdr_oam(oam), .i_hdr_vpi(vpi),
		.i_hdr_vci(vci), .i_udt_vpi(uv), .i_udt_vci(uc), .i_lut_done(ld), .i_lut_known(lk),
		.o_cell_keep(keep), .o_cell_drop(drop), .o_lut_req(lreq),
		.o_cell_port_config(cfgo), .o_header_lookup_bits(lkbo));
	ucfg_far_end far (.i_run(run), .i_addr(pa), .o_clk(lclk), .o_rx_addr(rxa), .o_tx_addr(txa));

	task automatic print_verdict();
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask
	// Bounded wait; running out ends the run as a failure
	task automatic wait_lvl(ref logic s, input logic v, input int n);
		for (int i = 0; i < n && s !== v; i++) begin
			@(posedge clk);
			#1;
		end
		if (s !== v) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic t_regs();
		bus(0, 16'h4000, 16'h0);
		chk(rdd, 16'h0004);
		chk(cfgo, 16'h0004);
		bus(0, 16'h4002, 16'h0);
		chk(rdd, 16'h0000);
		// Twelve channel bits plus four path bits: sixteen in total
		bus(1, 16'h4002, 16'hfec4);
		bus(0, 16'h4002, 16'h0);
		chk(rdd, 16'h02c4);
		chk({6'h00, lkbo}, 16'h02c4);
		bus(1, 16'h4100, 16'hffff);
		bus(0, 16'h4100, 16'h0);
		chk(rdd, 16'h0000);
	endtask
	task automatic t_clk();
		logic s;
		bus(1, 16'h4000, 16'h0000);
		@(posedge clk);
		#1;
		chk({14'h0, rcoe, tcoe}, 16'h0003);
		s = rco;
		@(posedge clk);
		#1;
		chk({14'h0, rco, tco}, {14'h0, ~s, ~s});
		bus(1, 16'h4000, 16'h0004);
		@(posedge clk);
		#1;
		chk({14'h0, rcoe, tcoe}, 16'h0000);
	endtask
	// Entry: cfg, {oam, flow-control differs or route known, table result}, {keep, drop, request}
	task automatic t_cls();
		for (int k = 0; k < 10; k++) begin
			// Clock select and setup-done go in together, in one write of the config word
			bus(1, 16'h4000, tc[k]);
			@(posedge clk);
			hv <= ~tm[k][0];
			ld <= tm[k][0];
			lk <= tm[k][1];
			oam <= tm[k][2];
			vpi <= tm[k][1] ? 12'h923 : 12'h123;
			@(posedge clk);
			hv <= 1'b0;
			ld <= 1'b0;
			#1;
			chk({13'h0, keep, drop, lreq}, {13'h0, te[k]});
		end
	endtask
	task automatic t_rx();
		bus(1, 16'h4000, 16'h80a4);
		@(posedge clk);
		room <= 1'b1;
		run <= 1'b1;
		wait_lvl(rxe, 1'b0, 100);
		chk({14'h0, cavoe, cav}, 16'h0003);
		repeat (20) @(posedge clk);
		cend <= 1'b1;
		@(posedge clk);
		cend <= 1'b0;
		#1;
		chk({15'h0, rxe}, 16'h0001);
	endtask
	task automatic t_tx();
		bus(1, 16'h4000, 16'h81b4);
		@(posedge clk);
		tact <= 1'b1;
		tsoc <= 1'b1;
		wait_lvl(tsoco, 1'b1, 60);
		repeat (20) @(posedge clk);
		#1;
		chk(tbus, 16'h00ef);
		@(posedge clk);
		tact <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0, toe}, 16'h0001);
		bus(1, 16'h4000, 16'h80b4);
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0, toe}, 16'h0000);
	endtask

	// Level 2 with device address 3, then the bus moves to the idle address
	task automatic t_phy();
		@(posedge clk);
		tact <= 1'b1;
		pa <= 5'h03;
		bus(1, 16'h4000, 16'h8e04);
		repeat (20) @(posedge clk);
		#1;
		chk({14'h0, cavoe, toe}, 16'h0003);
		@(posedge clk);
		pa <= 5'h1f;
		repeat (20) @(posedge clk);
		#1;
		chk({14'h0, cavoe, toe}, 16'h0000);
		bus(1, 16'h4000, 16'hfe04);
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0, toe}, 16'h0000);
		bus(1, 16'h4000, 16'h8c04);
		repeat (20) @(posedge clk);
		#1;
		chk({15'h0, toe}, 16'h0001);
		chk(tbus, 16'hbeef);
	endtask
	// Second reset in mid-run must restore the reset contents
	task automatic t_rst();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(cfgo, 16'h0004);
		chk({15'h0, rxe}, 16'h0001);
		bus(0, 16'h4002, 16'h0);
		chk(rdd, 16'h0000);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{arst_n, wr, rd, run, room, cend, tsoc, tact, hv, oam, ld, lk} = '0;
		{addr, wd} = '0;
		tw = 16'hbeef;
		vci = 16'h0042;
		uc = 16'h0042;
		vpi = 12'h123;
		uv = 12'h123;
		pa = 5'h00;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_clk();
		t_cls();
		t_rx();
		t_tx();
		t_phy();
		t_rst();
		print_verdict();
	end
endmodule // utopia_port_config_bench
